// ==== hdl/cadlsb_core.sv ====
// Divide, compare, logic, shift and bit datapath with register file
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module cadlsb_core #(
  parameter int NUM_GPR = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Operation command
  input wire logic cmd_valid_in,
  input cadlsb_pkg::cadlsb_op_t cmd_op_in,
  input cadlsb_pkg::cadlsb_size_t cmd_size_in,
  input wire logic [3:0] cmd_dst_in,
  input wire logic [3:0] cmd_src_in,
  input wire logic cmd_use_imm_in,
  input wire logic [31:0] cmd_imm_in,
  input wire logic cmd_mem_in,
  input wire logic [7:0] mem_byte_in,
  // Operation status and memory write back
  output logic busy_out,
  output logic done_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic [3:0] flags_out,
  // Register access port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);
  import cadlsb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_WB} cadlsb_state_t;

  if (NUM_GPR != 8) begin : g_bad_gpr
    $error("NUM_GPR must be 8");
  end

  function automatic logic [31:0] sz_mask(input cadlsb_size_t s);
    unique case (s)
      SZ_BYTE: sz_mask = MASK_BYTE;
      SZ_WORD: sz_mask = MASK_WORD;
      default: sz_mask = MASK_LONG;
    endcase
  endfunction

  function automatic logic [31:0] sz_msb(input cadlsb_size_t s);
    unique case (s)
      SZ_BYTE: sz_msb = MSB_BYTE;
      SZ_WORD: sz_msb = MSB_WORD;
      default: sz_msb = MSB_LONG;
    endcase
  endfunction

  // Byte view: index bit 3 picks low half; word view: bit 3 picks extended half
  // sized register views
  function automatic logic [31:0] rd_view(input logic [31:0] r, input logic [3:0] i,
                                          input cadlsb_size_t s);
    unique case (s)
      SZ_BYTE: rd_view = i[3] ? {24'h0, r[7:0]} : {24'h0, r[15:8]};
      SZ_WORD: rd_view = i[3] ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
      default: rd_view = r;
    endcase
  endfunction

  // merge sized result into its register
  function automatic logic [31:0] wr_view(input logic [31:0] r, input logic [3:0] i,
                                          input cadlsb_size_t s, input logic [31:0] v);
    unique case (s)
      SZ_BYTE: wr_view = i[3] ? {r[31:8], v[7:0]} : {r[31:16], v[7:0], r[7:0]};
      SZ_WORD: wr_view = i[3] ? {v[15:0], r[15:0]} : {r[31:16], v[15:0]};
      default: wr_view = v;
    endcase
  endfunction

  function automatic logic [31:0] mag(input logic [31:0] v, input cadlsb_size_t s);
    mag = ((v & sz_msb(s)) != 32'h0) ? ((~v + 32'h1) & sz_mask(s)) : v;
  endfunction

  logic [31:0] gpr_reg [NUM_GPR];
  logic [3:0] flags_reg;
  cadlsb_state_t st_reg;
  logic done_reg;
  logic mem_wr_reg;
  logic [7:0] mem_wdata_reg;
  logic [31:0] rdata_reg;
  logic [16:0] rem_reg;
  logic [15:0] dq_reg;
  logic [15:0] dvs_reg;
  logic [4:0] cnt_reg;
  logic dsgn_reg;
  logic qneg_reg;
  logic rneg_reg;
  logic dword_reg;
  logic dvs_msb_reg;
  logic [3:0] ddst_reg;

  // Command decode
  wire logic accept = cmd_valid_in && (st_reg == ST_IDLE);
  wire logic is_div = (cmd_op_in == DIV_UNSIGNED_OP) || (cmd_op_in == DIV_SIGNED_OP);
  wire logic is_bit = (cmd_op_in >= BIT_FORCE_ONE_OP);
  wire logic bit_wr = (cmd_op_in == BIT_FORCE_ONE_OP) || (cmd_op_in == BIT_FORCE_ZERO_OP)
                      || (cmd_op_in == BIT_TOGGLE_OP);
  wire logic carry_flag = flags_reg[FLAG_C];
  // bit operations are always byte sized
  wire cadlsb_size_t eff_size = is_bit ? SZ_BYTE : cmd_size_in;
  wire cadlsb_size_t up_size = (cmd_size_in == SZ_BYTE) ? SZ_WORD : SZ_LONG;
  wire logic [31:0] mask = sz_mask(eff_size);
  wire logic [31:0] msb = sz_msb(eff_size);
  wire logic [2:0] dst_sel = cmd_dst_in[2:0];
  wire logic [31:0] dst_long = gpr_reg[dst_sel];
  wire logic [31:0] src_long = gpr_reg[cmd_src_in[2:0]];
  wire logic [31:0] op_a = rd_view(dst_long, cmd_dst_in, eff_size);
  wire logic [31:0] src_val = rd_view(src_long, cmd_src_in, eff_size);
  wire logic [31:0] op_b = cmd_use_imm_in ? (cmd_imm_in & mask) : src_val;

  // Bit operand and bit number
  wire logic [7:0] bit_byte = cmd_mem_in ? mem_byte_in : op_a[7:0];
  // immediate or low three register bits
  // inverted form takes only the immediate
  wire logic imm_bit = cmd_use_imm_in || (cmd_op_in == CARRY_CONJ_INV_BIT_OP);
  wire logic [2:0] bit_no = imm_bit ? cmd_imm_in[2:0] : src_val[2:0];
  wire logic [7:0] bit_onehot = 8'h01 << bit_no;
  wire logic bit_val = bit_byte[bit_no];

  // Shared subtractor for compare and negate
  wire logic [31:0] sub_x = (cmd_op_in == NEGATE_OP) ? 32'h0 : op_a;
  wire logic [31:0] sub_y = (cmd_op_in == NEGATE_OP) ? op_a : op_b;
  wire logic [32:0] sub_w = {1'b0, sub_x} - {1'b0, sub_y};
  wire logic [31:0] sub_r = sub_w[31:0] & mask;
  wire logic sub_v = ((sub_x ^ sub_y) & (sub_x ^ sub_r) & msb) != 32'h0;
  wire logic a_top = (op_a & msb) != 32'h0;
  wire logic [31:0] shl = (op_a << 1) & mask;
  wire logic [31:0] shr = op_a >> 1;

  logic [31:0] res;
  logic [7:0] bres;
  logic [3:0] aflags;
  logic upd_nz;
  logic awr;

  always_comb begin
    res = op_a;
    bres = bit_byte;
    aflags = flags_reg;
    upd_nz = 1'b0;
    awr = 1'b0;
    unique case (cmd_op_in)
      COMPARE_OP: begin
        res = sub_r;
        upd_nz = 1'b1;
        aflags[FLAG_V] = sub_v;
        aflags[FLAG_C] = sub_w[32];
      end
      NEGATE_OP: begin
        res = sub_r;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = sub_v;
        aflags[FLAG_C] = sub_w[32];
      end
      SIGN_EXTEND_OP: begin
        res = (cmd_size_in == SZ_LONG) ? {{16{op_a[15]}}, op_a[15:0]}
                                       : {16'h0, {8{op_a[7]}}, op_a[7:0]};
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      ZERO_EXTEND_OP: begin
        res = (cmd_size_in == SZ_LONG) ? {16'h0, op_a[15:0]} : {24'h0, op_a[7:0]};
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      AND_OP: begin
        res = op_a & op_b;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      OR_OP: begin
        res = op_a | op_b;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      XOR_OP: begin
        res = op_a ^ op_b;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      NOT_OP: begin
        res = ~op_a & mask;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_V] = 1'b0;
      end
      ARITH_SHIFT_LEFT_OP: begin
        res = shl;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = a_top;
        aflags[FLAG_V] = a_top != ((shl & msb) != 32'h0);
      end
      ARITH_SHIFT_RIGHT_OP: begin
        res = shr | (op_a & msb);
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = op_a[0];
        aflags[FLAG_V] = 1'b0;
      end
      LOGIC_SHIFT_LEFT_OP: begin
        res = shl;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = a_top;
        aflags[FLAG_V] = 1'b0;
      end
      LOGIC_SHIFT_RIGHT_OP: begin
        res = shr;
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = op_a[0];
        aflags[FLAG_V] = 1'b0;
      end
      ROTATE_LEFT_OP: begin
        res = shl | {31'h0, a_top};
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = a_top;
        aflags[FLAG_V] = 1'b0;
      end
      ROTATE_RIGHT_OP: begin
        res = shr | (op_a[0] ? msb : 32'h0);
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = op_a[0];
        aflags[FLAG_V] = 1'b0;
      end
      ROTATE_CARRY_LEFT_OP: begin
        res = shl | {31'h0, carry_flag};
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = a_top;
        aflags[FLAG_V] = 1'b0;
      end
      ROTATE_CARRY_RIGHT_OP: begin
        res = shr | (carry_flag ? msb : 32'h0);
        upd_nz = 1'b1;
        awr = 1'b1;
        aflags[FLAG_C] = op_a[0];
        aflags[FLAG_V] = 1'b0;
      end
      BIT_FORCE_ONE_OP: bres = bit_byte | bit_onehot;
      BIT_FORCE_ZERO_OP: bres = bit_byte & ~bit_onehot;
      BIT_TOGGLE_OP: bres = bit_byte ^ bit_onehot;
      BIT_PROBE_OP: aflags[FLAG_Z] = !bit_val;
      CARRY_CONJ_BIT_OP: aflags[FLAG_C] = carry_flag & bit_val;
      CARRY_CONJ_INV_BIT_OP: aflags[FLAG_C] = carry_flag & !bit_val;
      default: res = op_a;
    endcase
    if (is_bit) begin
      res = {24'h0, bres};
      awr = bit_wr && !cmd_mem_in;
    end
    // negative and zero from the sized result
    if (upd_nz) begin
      aflags[FLAG_N] = (res & msb) != 32'h0;
      aflags[FLAG_Z] = (res & mask) == 32'h0;
    end
  end

  // Divider set-up: dividend is the next size up, operands taken as magnitudes
  // signed operands become magnitudes
  wire logic sgn = (cmd_op_in == DIV_SIGNED_OP);
  wire logic [31:0] dvd = rd_view(dst_long, cmd_dst_in, up_size);
  wire logic [31:0] dvd_m = sgn ? mag(dvd, up_size) : dvd;
  wire logic [31:0] dvs_m = sgn ? mag(src_val, cmd_size_in) : src_val;
  wire logic dvd_neg = (dvd & sz_msb(up_size)) != 32'h0;
  wire logic dvs_neg = (src_val & sz_msb(cmd_size_in)) != 32'h0;
  wire logic byte_div = (cmd_size_in == SZ_BYTE);

  // Restoring step; a zero divisor yields an all-ones quotient before sign correction, never stalls
  // fixed step count
  wire logic [16:0] dshift = {rem_reg[15:0], dq_reg[15]};
  wire logic dge = dshift >= {1'b0, dvs_reg};
  wire logic [16:0] dsub = dshift - {1'b0, dvs_reg};
  wire cadlsb_size_t dsz = dword_reg ? SZ_WORD : SZ_BYTE;
  wire cadlsb_size_t dup = dword_reg ? SZ_LONG : SZ_WORD;
  wire logic [31:0] q_m = dword_reg ? {16'h0, dq_reg} : {24'h0, dq_reg[7:0]};
  wire logic [31:0] r_m = {16'h0, rem_reg[15:0]} & sz_mask(dsz);
  wire logic [31:0] q_f = qneg_reg ? ((32'h0 - q_m) & sz_mask(dsz)) : q_m;
  wire logic [31:0] r_f = rneg_reg ? ((32'h0 - r_m) & sz_mask(dsz)) : r_m;
  wire logic [31:0] d_res = dword_reg ? {r_f[15:0], q_f[15:0]} : {16'h0, r_f[7:0], q_f[7:0]};
  wire logic q_top = (q_f & sz_msb(dsz)) != 32'h0;
  wire logic [3:0] dflags = {dsgn_reg ? q_top : dvs_msb_reg, dvs_reg == 16'h0,
                             flags_reg[FLAG_V], flags_reg[FLAG_C]};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 5'h0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (accept && is_div) begin
            st_reg <= ST_DIV;
            cnt_reg <= (byte_div ? DIV_STEPS_BYTE : DIV_STEPS_WORD) - 5'h1;
          end
        end
        ST_DIV: begin
          cnt_reg <= cnt_reg - 5'h1;
          if (cnt_reg == 5'h0) begin
            st_reg <= ST_WB;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (accept && is_div) begin
      rem_reg <= byte_div ? {9'h0, dvd_m[15:8]} : {1'b0, dvd_m[31:16]};
      dq_reg <= byte_div ? {dvd_m[7:0], 8'h0} : dvd_m[15:0];
      dvs_reg <= dvs_m[15:0];
      dsgn_reg <= sgn;
      qneg_reg <= sgn && (dvd_neg != dvs_neg);
      rneg_reg <= sgn && dvd_neg;
      dword_reg <= !byte_div;
      dvs_msb_reg <= dvs_neg;
      ddst_reg <= cmd_dst_in;
    end else if (st_reg == ST_DIV) begin
      rem_reg <= dge ? dsub : dshift;
      dq_reg <= {dq_reg[14:0], dge};
    end
  end

  // Register file and flags; datapath writes win over the access port
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_reg[i] <= GPR_RESET;
      end
      flags_reg <= FLAGS_RESET;
    end else if (st_reg == ST_WB) begin
      gpr_reg[ddst_reg[2:0]] <= wr_view(gpr_reg[ddst_reg[2:0]], ddst_reg, dup, d_res);
      flags_reg <= dflags;
    end else if (accept && !is_div) begin
      if (awr) begin
        gpr_reg[dst_sel] <= wr_view(dst_long, cmd_dst_in, eff_size, res);
      end
      flags_reg <= aflags;
    end else if (reg_wr_in) begin
      if (!reg_addr_in[3]) begin
        gpr_reg[reg_addr_in[2:0]] <= reg_wdata_in;
      end else if (reg_addr_in == REG_ADDR_FLAGS) begin
        flags_reg <= reg_wdata_in[3:0];
      end
    end
  end

  // Done pulse, memory write back and read data
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      done_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= 8'h0;
      rdata_reg <= 32'h0;
    end else begin
      done_reg <= (accept && !is_div) || (st_reg == ST_WB);
      mem_wr_reg <= accept && bit_wr && cmd_mem_in;
      if (accept && bit_wr && cmd_mem_in) begin
        mem_wdata_reg <= bres;
      end
      if (!reg_rd_in) begin
        rdata_reg <= 32'h0;
      end else if (!reg_addr_in[3]) begin
        rdata_reg <= gpr_reg[reg_addr_in[2:0]];
      end else begin
        rdata_reg <= (reg_addr_in == REG_ADDR_FLAGS) ? {28'h0, flags_reg} : 32'h0;
      end
    end
  end

  assign busy_out = (st_reg != ST_IDLE);
  assign done_out = done_reg;
  assign mem_wr_out = mem_wr_reg;
  assign mem_wdata_out = mem_wdata_reg;
  assign flags_out = flags_reg;
  assign reg_rdata_out = rdata_reg;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_div_busy8;
    busy_out [*8];
  endsequence

  sequence s_div_busy16;
    s_div_busy8 ##1 s_div_busy8;
  endsequence

  a_div_byte_time: assert property (
    accept && is_div && byte_div |=> s_div_busy8 ##1 busy_out ##1 done_out && !busy_out)
    else $error("byte divide not done after ten cycles");
  a_div_word_time: assert property (
    accept && is_div && !byte_div |=> s_div_busy16 ##1 busy_out ##1 done_out)
    else $error("word divide not done after eighteen cycles");
  a_single_done: assert property (
    accept && !is_div |=> done_out && !busy_out)
    else $error("single cycle operation missed done");
  a_cmp_keeps_reg: assert property (
    accept && cmd_op_in == COMPARE_OP |=> gpr_reg[$past(dst_sel)] == $past(dst_long))
    else $error("compare changed its destination");
  a_neg_long_value: assert property (
    accept && cmd_op_in == NEGATE_OP && cmd_size_in == SZ_LONG
    |=> gpr_reg[$past(dst_sel)] == 32'h0 - $past(dst_long))
    else $error("negate result wrong");
  a_not_long_value: assert property (
    accept && cmd_op_in == NOT_OP && cmd_size_in == SZ_LONG
    |=> gpr_reg[$past(dst_sel)] == ~$past(dst_long))
    else $error("invert result wrong");
  a_rotc_carry_in: assert property (
    accept && cmd_op_in == ROTATE_CARRY_LEFT_OP && cmd_size_in == SZ_LONG
    |=> gpr_reg[$past(dst_sel)][0] == $past(carry_flag))
    else $error("carry did not enter rotation");
  a_probe_zero_flag: assert property (
    accept && cmd_op_in == BIT_PROBE_OP |=> flags_reg[FLAG_Z] == !$past(bit_val))
    else $error("bit probe zero flag wrong");
  a_carry_conj_bit: assert property (
    accept && cmd_op_in == CARRY_CONJ_BIT_OP
    |=> carry_flag == ($past(carry_flag) && $past(bit_val)))
    else $error("carry conjunction wrong");
  a_carry_inv_bit: assert property (
    accept && cmd_op_in == CARRY_CONJ_INV_BIT_OP
    |=> carry_flag == ($past(carry_flag) && !$past(bit_val)))
    else $error("inverted carry conjunction wrong");
  a_mem_force_one: assert property (
    accept && cmd_op_in == BIT_FORCE_ONE_OP && cmd_mem_in
    |=> mem_wr_out && mem_wdata_out == ($past(bit_byte) | $past(bit_onehot)))
    else $error("memory bit set wrong");
  a_mem_force_zero: assert property (
    accept && cmd_op_in == BIT_FORCE_ZERO_OP && cmd_mem_in
    |=> mem_wr_out && mem_wdata_out == ($past(bit_byte) & ~$past(bit_onehot)))
    else $error("memory bit clear wrong");
endmodule

// ==== inc/cadlsb_pkg.sv ====
// Types and constants for the divide, logic, shift and bit datapath
package cadlsb_pkg;
  typedef enum logic [4:0] {
    DIV_UNSIGNED_OP, DIV_SIGNED_OP, COMPARE_OP, NEGATE_OP,
    SIGN_EXTEND_OP, ZERO_EXTEND_OP, AND_OP, OR_OP, XOR_OP, NOT_OP,
    ARITH_SHIFT_LEFT_OP, ARITH_SHIFT_RIGHT_OP,
    LOGIC_SHIFT_LEFT_OP, LOGIC_SHIFT_RIGHT_OP,
    ROTATE_LEFT_OP, ROTATE_RIGHT_OP,
    ROTATE_CARRY_LEFT_OP, ROTATE_CARRY_RIGHT_OP,
    BIT_FORCE_ONE_OP, BIT_FORCE_ZERO_OP, BIT_TOGGLE_OP, BIT_PROBE_OP,
    CARRY_CONJ_BIT_OP, CARRY_CONJ_INV_BIT_OP
  } cadlsb_op_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cadlsb_size_t;
  localparam logic [3:0] REG_ADDR_FLAGS = 4'h8;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] GPR_RESET = 32'h0;
  localparam logic [4:0] DIV_STEPS_BYTE = 5'h08;
  localparam logic [4:0] DIV_STEPS_WORD = 5'h10;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] MASK_WORD = 32'h0000_ffff;
  localparam logic [31:0] MASK_LONG = 32'hffff_ffff;
  localparam logic [31:0] MSB_BYTE = 32'h0000_0080;
  localparam logic [31:0] MSB_WORD = 32'h0000_8000;
  localparam logic [31:0] MSB_LONG = 32'h8000_0000;
endpackage

// ==== bench/cadlsb_mem_model.sv ====
// Memory byte model feeding the bit datapath and taking its write-backs
`timescale 1ns/1ns
module cadlsb_mem_model #(
  parameter logic [7:0] INIT_BYTE = 8'h3c
) (
  // Clock
  input wire logic ref_clk_in,
  // Write back from the datapath
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  // Byte presented with each request
  output logic [7:0] mem_byte_out
);
  initial mem_byte_out = INIT_BYTE;
  always @(posedge ref_clk_in) begin
    if (mem_wr_in === 1'b1) begin
      mem_byte_out <= mem_wdata_in;
    end
  end
endmodule

// ==== bench/tb_cpu_alu_div_logic_shift_bit.sv ====
// Self-checking bench for the divide, logic, shift and bit datapath
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("unexpected %0t mismatch got %h want %h", $time, g, e); end end
module tb_cpu_alu_div_logic_shift_bit;
  import cadlsb_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  cadlsb_op_t cmd_op_in = NOT_OP;
  cadlsb_size_t cmd_size_in = SZ_BYTE;
  logic [3:0] cmd_dst_in = 4'h0;
  logic [3:0] cmd_src_in = 4'h0;
  logic cmd_use_imm_in = 1'b0;
  logic [31:0] cmd_imm_in = 32'h0;
  logic cmd_mem_in = 1'b0;
  logic [7:0] mem_byte_in;
  logic busy_out, done_out, mem_wr_out;
  logic [7:0] mem_wdata_out;
  logic [3:0] flags_out;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [31:0] rdv;
  int miscompares = 0;
  int cmp_count = 0;
  int lat;
  always #20 ref_clk_in = ~ref_clk_in;
  cadlsb_core u_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_size_in(cmd_size_in), .cmd_dst_in(cmd_dst_in), .cmd_src_in(cmd_src_in),
    .cmd_use_imm_in(cmd_use_imm_in), .cmd_imm_in(cmd_imm_in), .cmd_mem_in(cmd_mem_in),
    .mem_byte_in(mem_byte_in), .busy_out(busy_out), .done_out(done_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .flags_out(flags_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
  cadlsb_mem_model u_mem (.ref_clk_in(ref_clk_in), .mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out),
    .mem_byte_out(mem_byte_in));
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 rdv = reg_rdata_out;
  endtask
  // Issue one command and count cycles until done, bounded
  task automatic op(input cadlsb_op_t o, input cadlsb_size_t s, input logic [3:0] d, input logic [3:0] sr,
                    input logic [31:0] im, input logic ui, input logic m);
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_op_in <= o;
    cmd_size_in <= s;
    cmd_dst_in <= d;
    cmd_src_in <= sr;
    cmd_imm_in <= im;
    cmd_use_imm_in <= ui;
    cmd_mem_in <= m;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    // Done can stand in the very cycle after the accepting edge
    lat = 1;
    #1;
    while (done_out !== 1'b1 && lat < 40) begin
      @(posedge ref_clk_in);
      lat++;
      #1;
    end
    `CHK(done_out, 1'b1)
  endtask
  task automatic t_reset;
    rd(4'h3);
    `CHK(rdv, 32'h0)
    rd(4'h8);
    `CHK(rdv, 32'h0)
    wr(4'h8, 32'h5);
    rd(4'h8);
    `CHK(rdv, 32'h5)
    rd(4'hb);
    `CHK(rdv, 32'h0)
  endtask
  task automatic t_logic;
    wr(4'h1, 32'hf0f0_1234);
    wr(4'h2, 32'h0000_ffff);
    op(AND_OP, SZ_LONG, 4'h1, 4'h0, 32'h0ff0_ff00, 1'b1, 1'b0);
    op(OR_OP, SZ_BYTE, 4'h9, 4'h0, 32'h0f, 1'b1, 1'b0);
    op(XOR_OP, SZ_WORD, 4'h9, 4'h2, 32'h0, 1'b0, 1'b0);
    op(NOT_OP, SZ_BYTE, 4'h1, 4'h0, 32'h0, 1'b0, 1'b0);
    `CHK(lat, 1)
    rd(4'h1);
    `CHK(rdv, 32'hff0f_ed0f)
    `CHK(flags_out, 4'h9)
  endtask
  task automatic t_arith;
    wr(4'h3, 32'h1);
    op(NEGATE_OP, SZ_WORD, 4'h3, 4'h0, 32'h0, 1'b0, 1'b0);
    rd(4'h3);
    `CHK(rdv, 32'h0000_ffff)
    `CHK(flags_out, 4'h9)
    op(COMPARE_OP, SZ_WORD, 4'h3, 4'h0, 32'hffff, 1'b1, 1'b0);
    rd(4'h3);
    `CHK(rdv, 32'h0000_ffff)
    `CHK(flags_out, 4'h4)
    wr(4'h4, 32'h1234_8081);
    op(SIGN_EXTEND_OP, SZ_WORD, 4'h4, 4'h0, 32'h0, 1'b0, 1'b0);
    rd(4'h4);
    `CHK(rdv, 32'h1234_ff81)
    op(ZERO_EXTEND_OP, SZ_LONG, 4'h4, 4'h0, 32'h0, 1'b0, 1'b0);
    rd(4'h4);
    `CHK(rdv, 32'h0000_ff81)
  endtask
  task automatic shf(input cadlsb_op_t o, input logic [7:0] r, input logic [3:0] f);
    wr(4'h5, 32'h81);
    wr(4'h8, 32'h0);
    op(o, SZ_BYTE, 4'hd, 4'h0, 32'h0, 1'b0, 1'b0);
    rd(4'h5);
    `CHK(rdv, {24'h0, r})
    `CHK(flags_out, f)
  endtask
  task automatic t_shift;
    shf(ARITH_SHIFT_LEFT_OP, 8'h02, 4'h3);
    shf(ARITH_SHIFT_RIGHT_OP, 8'hc0, 4'h9);
    shf(LOGIC_SHIFT_LEFT_OP, 8'h02, 4'h1);
    shf(LOGIC_SHIFT_RIGHT_OP, 8'h40, 4'h1);
    shf(ROTATE_LEFT_OP, 8'h03, 4'h1);
    shf(ROTATE_RIGHT_OP, 8'hc0, 4'h9);
    shf(ROTATE_CARRY_LEFT_OP, 8'h02, 4'h1);
    shf(ROTATE_CARRY_RIGHT_OP, 8'h40, 4'h1);
    wr(4'h8, 32'h1);
    op(ROTATE_CARRY_LEFT_OP, SZ_LONG, 4'h5, 4'h0, 32'h0, 1'b0, 1'b0);
    rd(4'h5);
    `CHK(rdv, 32'h0000_0081)
    `CHK(flags_out, 4'h0)
  endtask
  task automatic t_bits;
    wr(4'h6, 32'ha5);
    wr(4'h7, 32'h05);
    op(BIT_FORCE_ONE_OP, SZ_BYTE, 4'he, 4'h0, 32'h1, 1'b1, 1'b0);
    op(BIT_FORCE_ZERO_OP, SZ_BYTE, 4'he, 4'hf, 32'h0, 1'b0, 1'b0);
    op(BIT_TOGGLE_OP, SZ_BYTE, 4'he, 4'h0, 32'h7, 1'b1, 1'b0);
    op(BIT_PROBE_OP, SZ_BYTE, 4'he, 4'h0, 32'h2, 1'b1, 1'b0);
    `CHK(flags_out[FLAG_Z], 1'b0)
    op(BIT_PROBE_OP, SZ_BYTE, 4'he, 4'h0, 32'h3, 1'b1, 1'b0);
    `CHK(flags_out[FLAG_Z], 1'b1)
    rd(4'h6);
    `CHK(rdv, 32'h07)
    wr(4'h8, 32'h1);
    op(CARRY_CONJ_BIT_OP, SZ_BYTE, 4'he, 4'h0, 32'h0, 1'b1, 1'b0);
    `CHK(flags_out[FLAG_C], 1'b1)
    op(CARRY_CONJ_INV_BIT_OP, SZ_BYTE, 4'he, 4'h0, 32'h0, 1'b1, 1'b0);
    `CHK(flags_out[FLAG_C], 1'b0)
    op(BIT_FORCE_ONE_OP, SZ_BYTE, 4'he, 4'h0, 32'h0, 1'b1, 1'b1);
    `CHK({mem_wr_out, mem_wdata_out}, 9'h13d)
    op(BIT_TOGGLE_OP, SZ_BYTE, 4'he, 4'h0, 32'h2, 1'b1, 1'b1);
    `CHK({mem_wr_out, mem_wdata_out}, 9'h139)
    rd(4'h6);
    `CHK(rdv, 32'h07)
  endtask
  task automatic t_div;
    wr(4'h0, 32'd100);
    wr(4'h1, 32'h07);
    op(DIV_UNSIGNED_OP, SZ_BYTE, 4'h0, 4'h9, 32'h0, 1'b0, 1'b0);
    `CHK(lat, 10)
    `CHK(busy_out, 1'b0)
    rd(4'h0);
    `CHK(rdv, 32'h0000_020e)
    `CHK(flags_out[3:2], 2'b00)
    wr(4'h2, 32'hffff_ff9c);
    wr(4'h3, 32'h07);
    op(DIV_SIGNED_OP, SZ_WORD, 4'h2, 4'h3, 32'h0, 1'b0, 1'b0);
    `CHK(lat, 18)
    rd(4'h2);
    `CHK(rdv, 32'hfffe_fff2)
    `CHK(flags_out[3:2], 2'b10)
    wr(4'h1, 32'h0);
    op(DIV_UNSIGNED_OP, SZ_BYTE, 4'h0, 4'h9, 32'h0, 1'b0, 1'b0);
    `CHK(lat, 10)
    rd(4'h0);
    `CHK(rdv[7:0], 8'hff)
    `CHK(flags_out[3:2], 2'b01)
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_logic();
    t_arith();
    t_shift();
    t_bits();
    t_div();
    give_verdict();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
